// ---- rtl/dmi_pkg.sv ----
// Constants for the data-memory indirect addressing block.
// Assumes an 8-bit core with two data-memory sectors of 256 bytes each.
package dmi_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int DMI_DW     = 8;
   localparam int DMI_AW     = 9;
   localparam int DMI_PC_W   = 12;
   localparam int DMI_DEPTH  = 512;

   ////////////////////////////////////////////////////////////////////////////
   // Offsets within every sector (mirrored in both sectors)
   localparam logic [7:0] DMI_OFS_IND0    = 8'h00;
   localparam logic [7:0] DMI_OFS_PTR0    = 8'h01;
   localparam logic [7:0] DMI_OFS_IND1    = 8'h02;
   localparam logic [7:0] DMI_OFS_PTR1_LO = 8'h03;
   localparam logic [7:0] DMI_OFS_PTR1_SC = 8'h04;
   localparam logic [7:0] DMI_OFS_IND2    = 8'h05;
   localparam logic [7:0] DMI_OFS_PTR2_LO = 8'h06;
   localparam logic [7:0] DMI_OFS_PTR2_SC = 8'h07;
   localparam logic [7:0] DMI_OFS_BANK    = 8'h08;
   localparam logic [7:0] DMI_OFS_PCL     = 8'h09;
   localparam logic [7:0] DMI_OFS_SPECIAL = 8'h0A;

   ////////////////////////////////////////////////////////////////////////////
   // Fields, limits and reset values
   localparam int          DMI_BANK_BIT   = 0;
   localparam logic [7:0]  DMI_NUM_SECT   = 8'h02;
   localparam logic [7:0]  DMI_NULL_READ  = 8'h00;
   localparam logic [7:0]  DMI_RST_BYTE   = 8'h00;
   localparam logic        DMI_RST_BANK   = 1'b0;
   localparam logic [11:0] DMI_RST_PC     = 12'h000;

endpackage

// ---- rtl/dmi_ram.sv ----
// Data-memory array with a registered read port.
// Assumes single-clock use; override lets the caller supply read data.
`timescale 1ns/100ps
module dmi_ram
   import dmi_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              we,
   input  wire logic [DMI_AW-1:0] addr,
   input  wire logic [DMI_DW-1:0] wdata,
   input  wire logic              re,
   input  wire logic              ovr,
   input  wire logic [DMI_DW-1:0] ovr_data,
   output logic      [DMI_DW-1:0] rdata_r
);

   logic [DMI_DW-1:0] mem [DMI_DEPTH];

   always_ff @(posedge sys_clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rdata_r <= DMI_RST_BYTE;
      end
      else if (re)
      begin
         rdata_r <= ovr ? ovr_data : mem[addr];
      end
   end

endmodule // dmi_ram

// ---- rtl/dmi_core.sv ----
// Data-memory addressing unit: pointers, indirect ports, bank select, pc.
// Assumes the instruction sequencer drives strobes on sys_clk.
//
// Summary of operation
// RL1: Indirect ports read 00H when unredirected; writing them stores nothing.
// RL2: Indirect port access goes to the location named by its pointer.
// RL3: Pointer zero path always stays inside sector 0.
// RL4: Ports one and two reach any sector through their pointer pairs.
// RL5: Sector byte picks the sector, low byte picks the address.
// RL6: All five pointers are real storage, read, written and incremented normally.
// RL7: Extended direct addresses are 9 bits, top bit selects the sector.
// RL8: Direct addressing reaches all sectors with extended instruction forms.
// RL9: Bank select holds bit 0, resets to 0, chooses bank 0 or 1.
// RL10: Upper seven bank select bits always read zero.
// RL11: Jumps and calls land in the bank chosen by the bank bit.
// RL12: Writing pc low byte replaces only the low pc byte.
// RL13: A pc low byte write inserts one dummy cycle.
// RL14: Results live in the accumulator; memory writes come only from it.
// RL15: Pointer zero is a full 8-bit offset and wraps in 8 bits.
`timescale 1ns/100ps
module dmi_core
   import dmi_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic [DMI_AW-1:0]   mem_addr,
   input  wire logic                mem_ext,
   input  wire logic                mem_wr,
   input  wire logic                mem_rd,
   input  wire logic                mem_rd_acc,
   input  wire logic                acc_wr,
   input  wire logic [DMI_DW-1:0]   acc_wdata,
   input  wire logic                pc_step,
   input  wire logic                branch_req,
   input  wire logic [DMI_PC_W-1:0] branch_target,
   output logic      [DMI_DW-1:0]   mem_rdata,
   output logic      [DMI_DW-1:0]   acc,
   output logic      [DMI_PC_W:0]   pc_addr,
   output logic                     dummy_cycle,
   output logic                     bank_sel
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [DMI_DW-1:0]   acc_r;
   logic [DMI_DW-1:0]   ptr_zero_r;
   logic [DMI_DW-1:0]   ptr_one_low_r;
   logic [DMI_DW-1:0]   ptr_one_sector_r;
   logic [DMI_DW-1:0]   ptr_two_low_r;
   logic [DMI_DW-1:0]   ptr_two_sector_r;
   logic                bank_r;
   logic [DMI_PC_W-1:0] pc_r;
   logic                pc_bank_r;
   logic                dummy_r;
   logic                rd_acc_pend_r;
   logic [DMI_DW-1:0]   ram_q;

   ////////////////////////////////////////////////////////////////////////////
   // Direct address, sector bit only for extended forms
   wire [DMI_AW-1:0] dir_addr = {mem_ext & mem_addr[DMI_AW-1], mem_addr[7:0]}; // [RL7] [RL8]
   wire [7:0]        dir_ofs  = dir_addr[7:0];

   wire sel_ind0 = (dir_ofs == DMI_OFS_IND0);
   wire sel_ind1 = (dir_ofs == DMI_OFS_IND1);
   wire sel_ind2 = (dir_ofs == DMI_OFS_IND2);

   ////////////////////////////////////////////////////////////////////////////
   // Effective address through the pointers
   wire ind1_ok = (ptr_one_sector_r < DMI_NUM_SECT); // [RL4]
   wire ind2_ok = (ptr_two_sector_r < DMI_NUM_SECT); // [RL4]

   wire [DMI_AW-1:0] ind0_addr = {1'b0, ptr_zero_r};                    // [RL3] [RL15]
   wire [DMI_AW-1:0] ind1_addr = {ptr_one_sector_r[0], ptr_one_low_r};  // [RL5]
   wire [DMI_AW-1:0] ind2_addr = {ptr_two_sector_r[0], ptr_two_low_r};  // [RL5]

   wire [DMI_AW-1:0] eff_addr = sel_ind0 ? ind0_addr :
                                sel_ind1 ? ind1_addr :
                                sel_ind2 ? ind2_addr : dir_addr;        // [RL2]
   wire              eff_ok   = sel_ind1 ? ind1_ok :
                                sel_ind2 ? ind2_ok : 1'b1;
   wire [7:0]        eff_ofs  = eff_addr[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the target location
   wire hit_ind  = (eff_ofs == DMI_OFS_IND0) | (eff_ofs == DMI_OFS_IND1) |
                   (eff_ofs == DMI_OFS_IND2);
   wire hit_p0   = (eff_ofs == DMI_OFS_PTR0);
   wire hit_p1l  = (eff_ofs == DMI_OFS_PTR1_LO);
   wire hit_p1s  = (eff_ofs == DMI_OFS_PTR1_SC);
   wire hit_p2l  = (eff_ofs == DMI_OFS_PTR2_LO);
   wire hit_p2s  = (eff_ofs == DMI_OFS_PTR2_SC);
   wire hit_bank = (eff_ofs == DMI_OFS_BANK);
   wire hit_pcl  = (eff_ofs == DMI_OFS_PCL);
   wire hit_spec = (eff_ofs < DMI_OFS_SPECIAL);

   wire wr_ok    = mem_wr & eff_ok & ~hit_ind; // [RL1]
   wire wr_p0    = wr_ok & hit_p0;
   wire wr_p1l   = wr_ok & hit_p1l;
   wire wr_p1s   = wr_ok & hit_p1s;
   wire wr_p2l   = wr_ok & hit_p2l;
   wire wr_p2s   = wr_ok & hit_p2s;
   wire wr_bank  = wr_ok & hit_bank;
   wire wr_pcl   = wr_ok & hit_pcl;
   wire ram_we   = wr_ok & ~hit_spec;

   ////////////////////////////////////////////////////////////////////////////
   // Read value of the special locations
   wire [DMI_DW-1:0] bank_rd = {7'b000_0000, bank_r}; // [RL9] [RL10]

   wire [DMI_DW-1:0] spec_val =
      hit_p0   ? ptr_zero_r       :
      hit_p1l  ? ptr_one_low_r    :
      hit_p1s  ? ptr_one_sector_r :
      hit_p2l  ? ptr_two_low_r    :
      hit_p2s  ? ptr_two_sector_r :
      hit_bank ? bank_rd          :
      hit_pcl  ? pc_r[7:0]        : DMI_NULL_READ;   // [RL6]

   wire              rd_ovr  = ~eff_ok | hit_spec;
   wire [DMI_DW-1:0] rd_oval = (~eff_ok | hit_ind) ? DMI_NULL_READ : spec_val; // [RL1]
   wire              rd_any  = mem_rd | mem_rd_acc;

   ////////////////////////////////////////////////////////////////////////////
   // Data memory array
   dmi_ram u_ram
   (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .we       (ram_we),
      .addr     (eff_addr),
      .wdata    (acc_r),
      .re       (rd_any),
      .ovr      (rd_ovr),
      .ovr_data (rd_oval),
      .rdata_r  (ram_q)
   );

   assign mem_rdata = ram_q;

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator
   wire [DMI_DW-1:0] acc_nxt = acc_wr        ? acc_wdata :
                               rd_acc_pend_r ? ram_q     : acc_r; // [RL14]

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         acc_r <= DMI_RST_BYTE;
      end
      else
      begin
         acc_r <= acc_nxt; // [RL14]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rd_acc_pend_r <= 1'b0;
      end
      else
      begin
         rd_acc_pend_r <= mem_rd_acc;
      end
   end

   assign acc = acc_r;

   ////////////////////////////////////////////////////////////////////////////
   // Pointer registers, written from the accumulator
   wire [DMI_DW-1:0] ptr_zero_nxt       = wr_p0  ? acc_r : ptr_zero_r;       // [RL6] [RL15]
   wire [DMI_DW-1:0] ptr_one_low_nxt    = wr_p1l ? acc_r : ptr_one_low_r;    // [RL6]
   wire [DMI_DW-1:0] ptr_one_sector_nxt = wr_p1s ? acc_r : ptr_one_sector_r; // [RL6]
   wire [DMI_DW-1:0] ptr_two_low_nxt    = wr_p2l ? acc_r : ptr_two_low_r;    // [RL6]
   wire [DMI_DW-1:0] ptr_two_sector_nxt = wr_p2s ? acc_r : ptr_two_sector_r; // [RL6]

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ptr_zero_r <= DMI_RST_BYTE;
      end
      else
      begin
         ptr_zero_r <= ptr_zero_nxt; // [RL6] [RL15]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ptr_one_low_r <= DMI_RST_BYTE;
      end
      else
      begin
         ptr_one_low_r <= ptr_one_low_nxt; // [RL6]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ptr_one_sector_r <= DMI_RST_BYTE;
      end
      else
      begin
         ptr_one_sector_r <= ptr_one_sector_nxt; // [RL6]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ptr_two_low_r <= DMI_RST_BYTE;
      end
      else
      begin
         ptr_two_low_r <= ptr_two_low_nxt; // [RL6]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ptr_two_sector_r <= DMI_RST_BYTE;
      end
      else
      begin
         ptr_two_sector_r <= ptr_two_sector_nxt; // [RL6]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program bank select
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         bank_r <= DMI_RST_BANK; // [RL9]
      end
      else if (wr_bank)
      begin
         bank_r <= acc_r[DMI_BANK_BIT]; // [RL9]
      end
   end

   assign bank_sel = bank_r;

   ////////////////////////////////////////////////////////////////////////////
   // Program counter
   wire              pc_run  = ~dummy_r;
   wire [DMI_PC_W-1:0] pc_inc = pc_r + 12'h001;
   wire [DMI_PC_W-1:0] pcl_new = {pc_r[DMI_PC_W-1:8], acc_r}; // [RL12]

   wire [DMI_PC_W-1:0] pc_nxt =
      wr_pcl                ? pcl_new       :
      (branch_req & pc_run) ? branch_target :
      (pc_step & pc_run)    ? pc_inc        : pc_r;
   wire pc_bank_nxt = (~wr_pcl & branch_req & pc_run) ? bank_r : pc_bank_r; // [RL11]

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pc_r <= DMI_RST_PC;
      end
      else
      begin
         pc_r <= pc_nxt; // [RL12]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pc_bank_r <= DMI_RST_BANK;
      end
      else
      begin
         pc_bank_r <= pc_bank_nxt; // [RL11]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         dummy_r <= 1'b0;
      end
      else
      begin
         dummy_r <= wr_pcl; // [RL13]
      end
   end

   assign pc_addr     = {pc_bank_r, pc_r};
   assign dummy_cycle = dummy_r;

endmodule // dmi_core

// ---- bench/dmi_core_assertions.sv ----
// Checker for the addressing unit, bound to its ports.
// Assumes one clock and synchronous active low reset.
`timescale 1ns/100ps
module dmi_core_checker
   import dmi_pkg::*;
(
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire logic [DMI_AW-1:0]   mem_addr,
   input wire logic                mem_ext,
   input wire logic                mem_wr,
   input wire logic                mem_rd,
   input wire logic                mem_rd_acc,
   input wire logic                acc_wr,
   input wire logic [DMI_DW-1:0]   acc_wdata,
   input wire logic                pc_step,
   input wire logic                branch_req,
   input wire logic [DMI_PC_W-1:0] branch_target,
   input wire logic [DMI_DW-1:0]   mem_rdata,
   input wire logic [DMI_DW-1:0]   acc,
   input wire logic [DMI_PC_W:0]   pc_addr,
   input wire logic                dummy_cycle,
   input wire logic                bank_sel
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire pclw = mem_wr && mem_addr[7:0] == DMI_OFS_PCL;
   wire bkw  = mem_wr && mem_addr[7:0] == DMI_OFS_BANK;
   a_acc_load: assert property (acc_wr |=> acc == $past(acc_wdata))
      else $error("acc load wrong");
   a_acc_from_mem: assert property (mem_rd_acc ##1 !(acc_wr || mem_rd || mem_rd_acc)
      |=> acc == mem_rdata) else $error("acc not from memory");
   a_pcl_low: assert property (pclw |=> pc_addr[7:0] == $past(acc)
      && pc_addr[12:8] == $past(pc_addr[12:8])) else $error("pc low write wrong");
   a_pcl_dummy: assert property (pclw |=> dummy_cycle)
      else $error("no dummy cycle");
   a_dummy_pulse: assert property (dummy_cycle && !pclw |=> !dummy_cycle)
      else $error("dummy cycle too long");
   a_dummy_hold: assert property (dummy_cycle && !pclw |=> $stable(pc_addr))
      else $error("pc moved in dummy cycle");
   a_branch_bank: assert property (branch_req && !dummy_cycle && !pclw
      |=> pc_addr == {$past(bank_sel), $past(branch_target)}) else $error("branch wrong");
   a_bank_write: assert property (bkw |=> bank_sel == $past(acc[DMI_BANK_BIT]))
      else $error("bank select write wrong");
   a_bank_read: assert property (mem_rd && mem_addr[7:0] == DMI_OFS_BANK
      |=> mem_rdata == {7'b000_0000, bank_sel}) else $error("bank select read wrong");
   c_branch: cover property (branch_req);
   c_dummy: cover property (dummy_cycle);
   c_rd_acc: cover property (mem_rd_acc);
endmodule // dmi_core_checker

bind dmi_core dmi_core_checker dmi_core_checker_i (.sys_clk, .rst_n, .mem_addr, .mem_ext,
   .mem_wr, .mem_rd, .mem_rd_acc, .acc_wr, .acc_wdata, .pc_step, .branch_req,
   .branch_target, .mem_rdata, .acc, .pc_addr, .dummy_cycle, .bank_sel);

// ---- bench/dmi_alu.sv ----
// Execution-side model: the result that the core loads into acc.
// Assumes acc comes straight from the unit under test.
`timescale 1ns/100ps
module dmi_alu
   import dmi_pkg::*;
(
   input wire logic [DMI_DW-1:0] acc,
   input wire logic              inc,
   input wire logic [DMI_DW-1:0] imm,
   output logic     [DMI_DW-1:0] acc_wdata
);
   // Increment or immediate, always via acc
   assign acc_wdata = inc ? acc + 8'h01 : imm;
endmodule // dmi_alu

// ---- bench/tb.sv ----
// Testbench for the addressing unit.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module tb import dmi_pkg::*;;
   logic        sys_clk, rst_n, mem_ext, mem_wr, mem_rd, mem_rd_acc, acc_wr, inc;
   logic        pc_step, branch_req, dummy_cycle, bank_sel;
   logic [8:0]  mem_addr;
   logic [7:0]  acc_wdata, imm, mem_rdata, acc;
   logic [11:0] branch_target;
   logic [12:0] pc_addr;
   int          n_mismatch = 0, n_tests = 0, cyc = 0;
   typedef struct packed {logic [8:0] wa; logic [7:0] v; logic [8:0] ra; logic [7:0] x;} dmi_row_t;
   dmi_row_t rows [10] = '{
      '{9'h040, 8'h11, 9'h040, 8'h11},
      '{9'h1F0, 8'h22, 9'h1F0, 8'h22},
      '{9'h001, 8'h40, 9'h000, 8'h11},
      '{9'h004, 8'h01, 9'h004, 8'h01},
      '{9'h003, 8'hF0, 9'h002, 8'h22},
      '{9'h002, 8'h33, 9'h1F0, 8'h33},
      '{9'h007, 8'h00, 9'h007, 8'h00},
      '{9'h006, 8'h40, 9'h005, 8'h11},
      '{9'h000, 8'h55, 9'h040, 8'h55},
      '{9'h008, 8'hFF, 9'h008, 8'h01}};
   dmi_core dmi_core_i (.sys_clk, .rst_n, .mem_addr, .mem_ext, .mem_wr, .mem_rd, .mem_rd_acc,
      .acc_wr, .acc_wdata, .pc_step, .branch_req, .branch_target, .mem_rdata, .acc,
      .pc_addr, .dummy_cycle, .bank_sel);
   dmi_alu dmi_alu_i (.acc, .inc, .imm, .acc_wdata);
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [12:0] g, input logic [12:0] e);
      n_tests++;
      if (g !== e)
      begin
         $display("ERROR %0t got %h expected %h", $time, g, e);
         n_mismatch++;
      end
   endtask
   task ld(input logic i, input logic [7:0] v);
      @(posedge sys_clk);
      acc_wr <= 1'b1; inc <= i; imm <= v;
      @(posedge sys_clk);
      acc_wr <= 1'b0;
      #1;
   endtask
   task st(input logic w, input logic r, input logic ra, input logic [8:0] a, input logic e);
      @(posedge sys_clk);
      mem_wr <= w; mem_rd <= r; mem_rd_acc <= ra; mem_addr <= a; mem_ext <= e;
      @(posedge sys_clk);
      mem_wr <= 1'b0; mem_rd <= 1'b0; mem_rd_acc <= 1'b0;
      #1;
   endtask
   task results;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         $display("ERROR %0t timeout", $time);
         n_mismatch++;
         results;
      end
   end
   initial
   begin
      {mem_ext, mem_wr, mem_rd, mem_rd_acc, acc_wr, inc, pc_step, branch_req} = '0;
      mem_addr = '0; imm = '0; branch_target = '0; rst_n = 0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (rows[k])
      begin
         ld(0, rows[k].v);
         st(1, 0, 0, rows[k].wa, 1);
         st(0, 1, 0, rows[k].ra, 1);
         chk(mem_rdata, rows[k].x);
         $display("row %0d done", k);
      end
      chk(bank_sel, 1'b1);
      ld(0, 8'h66);
      st(1, 0, 0, 9'h0F0, 1);
      st(0, 1, 0, 9'h1F0, 0);
      chk(mem_rdata, 8'h66);
      ld(0, 8'h00);
      st(1, 0, 0, 9'h001, 1);
      st(0, 1, 0, 9'h000, 1);
      chk(mem_rdata, 8'h00);
      ld(0, 8'hFF);
      st(1, 0, 0, 9'h001, 1);
      st(0, 0, 1, 9'h001, 1);
      ld(1, 8'h00);
      chk(acc, 8'h00);
      st(1, 0, 0, 9'h001, 1);
      st(0, 1, 0, 9'h001, 1);
      chk(mem_rdata, 8'h00);
      $display("memory tests done");
      @(posedge sys_clk);
      branch_req <= 1'b1; branch_target <= 12'h123;
      @(posedge sys_clk);
      branch_req <= 1'b0;
      #1 chk(pc_addr, 13'h1123);
      ld(0, 8'h45);
      @(posedge sys_clk);
      mem_wr <= 1'b1; mem_addr <= 9'h009;
      @(posedge sys_clk);
      mem_wr <= 1'b0; pc_step <= 1'b1;
      #1 chk(pc_addr, 13'h1145);
      chk(dummy_cycle, 1'b1);
      @(posedge sys_clk);
      pc_step <= 1'b0;
      #1 chk(pc_addr, 13'h1145);
      chk(dummy_cycle, 1'b0);
      @(posedge sys_clk);
      pc_step <= 1'b1;
      @(posedge sys_clk);
      pc_step <= 1'b0;
      #1 chk(pc_addr, 13'h1146);
      $display("pc tests done");
      @(posedge sys_clk);
      rst_n <= 1'b0;
      @(posedge sys_clk);
      rst_n <= 1'b1;
      #1 chk({bank_sel, acc}, 9'h000);
      chk(pc_addr, 13'h0000);
      $display("reset test done");
      results;
   end
endmodule // tb
